// ===== rtl/nfhi_host.v
`timescale 1ns/1ns
`include "nfhi_defs.vh"
// Operation
// - Command byte is written with command latch high on write strobe rise.
// - Address byte is written with address latch high on write strobe rise.
// - Data byte is written with both latches low on write strobe rise.
// - Host keeps chip select low through busy after read command.
// - Host holds write protect high for program data and busy periods; the host defers a change only while busy, not between program data bytes.
// - Address is four cycles, low bits first.
// - Host drives upper six bits low in the fourth address cycle.
// - Bus states decode from latch strobes with chip select low.
// - Chip select high for 100 ns after last read ends sequential read.
// - A page is programmed at most 3 times between erases; the host does not count this and leaves it to the user.
// - Read command and address are reissued at block boundary; the host does not track this and leaves it to the user.
module nfhi_host #(
  parameter integer STROBE_CYC = `NFHI_DIV_UP(`NFHI_STROBE_NS),
  parameter integer CEH_CYC    = `NFHI_DIV_UP(`NFHI_SELECT_HIGH_TERMINATE_NS),
  parameter integer WPS_CYC    = `NFHI_DIV_UP(`NFHI_WP_SETUP_NS)
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       req_valid,
  input  wire [1:0] req_op,
  input  wire [7:0] req_data,
  input  wire       req_last,
  input  wire       wp_enable,
  output reg        req_ready,
  output reg        rsp_valid,
  output reg  [7:0] rsp_data,
  output reg        busy,
  output reg        half_page_hi,
  output reg        cmd_latch,
  output reg        addr_latch,
  output reg        chip_sel_n,
  output reg        write_strobe_n,
  output reg        read_strobe_n,
  output reg        write_prot_n,
  output reg  [7:0] io_out,
  output reg        io_oe,
  input  wire [7:0] io_in,
  input  wire       ready_busy_n
);
  // ****************************************
  // State machine
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WLOW  = 3'h1;
  localparam [2:0] ST_WHIGH = 3'h2;
  localparam [2:0] ST_RLOW  = 3'h3;
  localparam [2:0] ST_RHIGH = 3'h4;
  localparam [2:0] ST_CEH   = 3'h5;
  localparam [2:0] ST_WPSET = 3'h6;

  reg [2:0] state_r;
  reg [7:0] cnt_r;
  reg [2:0] acyc_r;
  reg       last_r;

  // ****************************************
  // Helpers
  // ****************************************
  // Strobe widths are whole cycles so every pulse exceeds the device minimum
  function [7:0] nfhi_cyc;
    input integer n;
    begin
      nfhi_cyc = (n < 1) ? 8'h01 : n[7:0];
    end
  endfunction

  // ****************************************
  // Device status
  // ****************************************
  // Ready/busy is wired synchronously; sampled once for the busy flag
  always @(posedge mclk) begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= ~ready_busy_n;
  end

  // ****************************************
  // Pin sequencer
  // ****************************************
  // Sequencer for command, address, data writes and serial reads
  always @(posedge mclk) begin
    if (rst) begin
      state_r        <= ST_IDLE;
      cnt_r          <= 8'h00;
      acyc_r         <= 3'h0;
      last_r         <= 1'b0;
      req_ready      <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= 8'h00;
      half_page_hi   <= 1'b0;
      cmd_latch      <= 1'b0;
      addr_latch     <= 1'b0;
      chip_sel_n     <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      write_prot_n   <= 1'b0;
      io_out         <= 8'h00;
      io_oe          <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          req_ready <= 1'b0;
          if (wp_enable == write_prot_n) begin
            // Protect change waits out any busy period, then its setup before a write strobe
            if (!busy) begin
              write_prot_n <= ~wp_enable;
              cnt_r        <= nfhi_cyc(WPS_CYC);
              state_r      <= ST_WPSET;
            end
          end else if (req_valid && !req_ready) begin
            last_r     <= req_last;
            chip_sel_n <= 1'b0;
            cnt_r      <= nfhi_cyc(STROBE_CYC);
            cmd_latch  <= (req_op == `NFHI_OP_CMD);
            addr_latch <= (req_op == `NFHI_OP_ADDR);
            if (req_op == `NFHI_OP_RDATA) begin
              io_oe         <= 1'b0;
              read_strobe_n <= 1'b0;
              state_r       <= ST_RLOW;
            end else begin
              io_oe          <= 1'b1;
              write_strobe_n <= 1'b0;
              state_r        <= ST_WLOW;
              if (req_op == `NFHI_OP_ADDR) begin
                // Fourth cycle carries only the top two address bits
                io_out <= (acyc_r == 3'h3) ? {6'h00, req_data[1:0]} : req_data;
                acyc_r <= (acyc_r == 3'h3) ? 3'h0 : acyc_r + 3'h1;
              end else begin
                // Bytes pass as given; the per-page program limit stays with the user
                io_out <= req_data;
                if (req_op == `NFHI_OP_CMD)
                  acyc_r <= 3'h0;
              end
              if (req_op == `NFHI_OP_CMD && req_data == `NFHI_CMD_READ_LO)
                half_page_hi <= 1'b0;
              if (req_op == `NFHI_OP_CMD && req_data == `NFHI_CMD_READ_HI)
                half_page_hi <= 1'b1;
            end
          end
        end
        ST_WLOW: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            write_strobe_n <= 1'b1;
            cnt_r          <= nfhi_cyc(STROBE_CYC);
            state_r        <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            cmd_latch  <= 1'b0;
            addr_latch <= 1'b0;
            io_oe      <= 1'b0;
            req_ready  <= 1'b1;
            state_r    <= ST_IDLE;
          end
        end
        ST_RLOW: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            rsp_data      <= io_in;
            rsp_valid     <= 1'b1;
            read_strobe_n <= 1'b1;
            cnt_r         <= nfhi_cyc(STROBE_CYC);
            state_r       <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            if (last_r && busy) begin
              // A page transfer is under way; deselecting now would spoil the register load
              cnt_r <= 8'h01;
            end else if (last_r) begin
              // Deselect long enough to end the sequential read
              chip_sel_n <= 1'b1;
              cnt_r      <= nfhi_cyc(CEH_CYC);
              state_r    <= ST_CEH;
            end else begin
              req_ready <= 1'b1;
              state_r   <= ST_IDLE;
            end
          end
        end
        ST_CEH: begin
          // Ready only once the deselect has lasted the terminate time
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            req_ready <= 1'b1;
            state_r   <= ST_IDLE;
          end
        end
        ST_WPSET: begin
          // Hold off requests until the protect level has settled
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== include/nfhi_defs.vh
`ifndef NFHI_DEFS_VH
`define NFHI_DEFS_VH
// Operation codes on the user port
`define NFHI_OP_CMD    2'h0
`define NFHI_OP_ADDR   2'h1
`define NFHI_OP_WDATA  2'h2
`define NFHI_OP_RDATA  2'h3
// Geometry
`define NFHI_PAGE_BYTES   528
`define NFHI_MAIN_BYTES   512
`define NFHI_SPARE_BYTES  16
`define NFHI_BLOCK_PAGES  32
`define NFHI_BLOCKS       8192
`define NFHI_ADDR_CYCLES  3'h4
// Read mode commands setting the half page select bit
`define NFHI_CMD_READ_LO  8'h00
`define NFHI_CMD_READ_HI  8'h01
// Timing in ns and clock period in ns
`define NFHI_CLK_NS           40
`define NFHI_STROBE_NS        50
`define NFHI_SELECT_HIGH_TERMINATE_NS 100
`define NFHI_WP_SETUP_NS      100
`define NFHI_DIV_UP(t)        (((t) + `NFHI_CLK_NS - 1) / `NFHI_CLK_NS)
`endif

// ===== tb/nfhi_chk_sva.sv
`timescale 1ns/1ns
// ***
// Pin checker
// ***
module nfhi_chk (
  input wire       mclk,
  input wire       rst,
  input wire       cmd_latch,
  input wire       addr_latch,
  input wire       chip_sel_n,
  input wire       write_strobe_n,
  input wire       read_strobe_n,
  input wire [7:0] io_out,
  input wire       io_oe,
  input wire       rsp_valid,
  input wire       half_page_hi
);
  reg [1:0] acnt_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Address byte count; any command restarts it
  always @(posedge mclk) begin
    if (rst || cmd_latch) acnt_r <= 2'h0;
    else if (addr_latch && $rose(write_strobe_n)) acnt_r <= acnt_r + 2'h1;
  end
  AST_CMD: assert property (cmd_latch |-> !addr_latch && read_strobe_n && !chip_sel_n) else $error("cmd");
  AST_ADR: assert property (addr_latch |-> !cmd_latch && read_strobe_n) else $error("adr");
  AST_WR: assert property (!write_strobe_n |-> io_oe && !chip_sel_n && read_strobe_n) else $error("wr");
  AST_RD: assert property (!read_strobe_n |-> !io_oe && !cmd_latch && !addr_latch && write_strobe_n) else $error("rd");
  AST_CEH: assert property ($rose(chip_sel_n) |-> chip_sel_n [*3]) else $error("ceh");
  AST_RSP: assert property (rsp_valid |-> read_strobe_n && !$past(read_strobe_n)) else $error("rsp");
  AST_HALF: assert property ($rose(write_strobe_n) && cmd_latch && io_out == 8'h01 |-> ##[0:3] half_page_hi) else $error("half");
  AST_A4: assert property (addr_latch && !write_strobe_n && acnt_r == 2'h3 |-> io_out[7:2] == 6'h00) else $error("a4");
endmodule
bind nfhi_host nfhi_chk u_chk (.mclk, .rst, .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n,
  .read_strobe_n, .io_out, .io_oe, .rsp_valid, .half_page_hi);

// ===== tb/nfhi_dev.sv
`timescale 1ns/1ns
// ***
// Flash device model
// ***
module nfhi_dev (
  input  wire       cmd_latch,
  input  wire       addr_latch,
  input  wire       chip_sel_n,
  input  wire       write_strobe_n,
  input  wire       read_strobe_n,
  input  wire       write_prot_n,
  input  wire [7:0] io_out,
  output wire [7:0] io_in,
  output wire       ready_busy_n
);
  reg [7:0] cmd_r, col_r, a4_r, dat_r, dout_r = 8'h00;
  reg [1:0] acnt_r = 2'h0;
  reg       bsy_r = 1'b0;
  // Pull-up on the open drain line
  assign ready_busy_n = !bsy_r;
  // Released bus shows the inverse, so a stale byte never passes
  assign io_in = (!read_strobe_n && !chip_sel_n) ? dout_r : ~dout_r;
  // Latch on write strobe rise
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && cmd_latch) begin
      cmd_r = io_out;
      acnt_r = 2'h0;
      if (io_out == 8'h10 && write_prot_n) bsy_r = 1'b1;
    end else if (!chip_sel_n && addr_latch) begin
      if (acnt_r == 2'h0) col_r = io_out;
      if (acnt_r == 2'h3) a4_r = io_out;
      if (acnt_r == 2'h3) bsy_r = 1'b1;
      acnt_r = acnt_r + 2'h1;
    end else if (!chip_sel_n) dat_r = io_out;
  end
  // Busy lasts just over ten periods, ending off the clock edge to avoid a race; chip select is ignored
  always @(posedge bsy_r) #410 bsy_r = 1'b0;
  // Next byte and column step on strobe fall
  always @(negedge read_strobe_n) begin
    dout_r = col_r + 8'hA5;
    col_r = col_r + 8'h01;
  end
endmodule

// ===== tb/nfhi_host_test.sv
`timescale 1ns/1ns
// ***
// Testbench
// ***
module nfhi_host_test;
  reg        mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_last = 1'b0, wp_enable = 1'b0;
  reg  [1:0] req_op = 2'h0;
  reg  [7:0] req_data = 8'h00, got;
  wire       req_ready, rsp_valid, busy, half_page_hi, cmd_latch, addr_latch, chip_sel_n;
  wire       write_strobe_n, read_strobe_n, write_prot_n, io_oe, ready_busy_n;
  wire [7:0] rsp_data, io_out, io_in;
  integer    num_errors = 0, checks = 0, cyc = 0, i;
  always #20 mclk = ~mclk;
  nfhi_host uut (.mclk, .rst, .req_valid, .req_op, .req_data, .req_last, .wp_enable, .req_ready, .rsp_valid,
    .rsp_data, .busy, .half_page_hi, .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_prot_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  nfhi_dev dev (.cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n, .write_prot_n,
    .io_out, .io_in, .ready_busy_n);
  task chk(input string n, input [7:0] g, input [7:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  // One request, held until the ready pulse
  task op(input [1:0] o, input [7:0] d, input l);
    integer k;
    begin
      @(posedge mclk);
      req_valid <= 1'b1;
      req_op <= o;
      req_data <= d;
      req_last <= l;
      k = 0;
      do begin
        @(posedge mclk);
        k = k + 1;
      end while (req_ready !== 1'b1 && k < 40);
      req_valid <= 1'b0;
      got = rsp_data;
      if (k == 40) num_errors = num_errors + 1;
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("wpn", {7'h0, write_prot_n}, 8'h01);
    op(2'h0, 8'h01, 1'b0);
    repeat (2) @(posedge mclk);
    chk("half", {7'h0, half_page_hi}, 8'h01);
    chk("cmd", dev.cmd_r, 8'h01);
    for (i = 0; i < 4; i = i + 1) op(2'h1, i == 3 ? 8'hFF : 8'h10 + i[7:0], 1'b0);
    chk("col", dev.col_r, 8'h10);
    chk("a4", dev.a4_r, 8'h03);
    chk("bsy", {7'h0, busy}, 8'h01);
    chk("csb", {7'h0, chip_sel_n}, 8'h00);
    for (i = 0; i < 100 && busy !== 1'b0; i = i + 1) @(posedge mclk);
    chk("rdy", {7'h0, busy}, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      op(2'h3, 8'h00, i == 2);
      chk("rd", got, 8'hB5 + i[7:0]);
    end
    chk("cen", {7'h0, chip_sel_n}, 8'h01);
    op(2'h0, 8'h00, 1'b0);
    op(2'h0, 8'h80, 1'b0);
    chk("half", {7'h0, half_page_hi}, 8'h00);
    op(2'h2, 8'h3C, 1'b0);
    chk("dat", dev.dat_r, 8'h3C);
    wp_enable <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("wpn", {7'h0, write_prot_n}, 8'h00);
    op(2'h0, 8'h10, 1'b0);
    repeat (3) @(posedge mclk);
    chk("bsy", {7'h0, busy}, 8'h00);
    complete_run;
  end
endmodule
